/* shared/mscr_pkg.sv */
// Purpose: constants and types for the motor start-up configuration register bank
// Assumes: axi4-lite slave with 32-bit data, 12-bit byte address
// Notes: option registers are 8 bits wide and sit in the low byte of their word
package mscr_pkg;

  // ----------------------------------------------------------------
  // register map (index, byte address is four times the index)
  // ----------------------------------------------------------------
  localparam int NUM_OPT = 5;
  localparam int ADDR_W = 12;
  localparam logic [9:0] IDX_DETECT_REVERSE = 10'h023;
  localparam logic [9:0] IDX_CURRENT_BRAKE = 10'h024;
  localparam logic [9:0] IDX_STARTUP_ACCEL = 10'h025;
  localparam logic [9:0] IDX_HANDOVER_ALIGN = 10'h026;
  localparam logic [9:0] IDX_FAULT_SURGE = 10'h027;
  localparam logic [9:0] IDX_EVENT_STATUS = 10'h030;
  localparam logic [9:0] IDX_EVENT_MASK = 10'h031;

  // ----------------------------------------------------------------
  // reset values and bus answers
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_OPT = 8'h00;
  localparam logic [NUM_OPT-1:0] RST_MASK = 5'h00;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // decode scales
  // ----------------------------------------------------------------
  localparam logic [9:0] STILL_WINDOW_BASE_MS = 10'h050;
  localparam logic [7:0] ADVANCE_STEP_DEG = 8'h1e;
  localparam logic [11:0] HANDOVER_LOW_STEP_DHZ = 12'h008;
  localparam logic [11:0] HANDOVER_HIGH_STEP_DHZ = 12'h080;

  // ----------------------------------------------------------------
  // field layout of the option registers, as a packed struct per register
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0] stationary_judge_threshold;
    logic [1:0] post_sense_advance_angle;
    logic initial_speed_detect_enable;
    logic reverse_drive_enable;
    logic [1:0] reverse_brake_threshold;
  } mscr_opt1_s;

  typedef struct packed {
    logic [1:0] open_loop_current;
    logic [2:0] open_loop_ramp_rate;
    logic [2:0] brake_time_select;
  } mscr_opt2_s;

  typedef struct packed {
    logic [1:0] control_coefficient;
    logic [2:0] startup_accel_second_order;
    logic [2:0] startup_accel_first_order;
  } mscr_opt3_s;

  typedef struct packed {
    logic [4:0] closed_loop_handover_speed;
    logic [2:0] rotor_align_time;
  } mscr_opt4_s;

  typedef struct packed {
    logic no_motor_fault_enable;
    logic [2:0] lock_detector_enables;
    logic inductive_surge_guard_enable;
    logic mechanical_surge_guard_enable;
    logic mechanical_surge_guard_target;
    logic sense_release_mode;
  } mscr_opt5_s;

  typedef struct packed {
    mscr_opt1_s detect_reverse_options;
    mscr_opt2_s open_loop_current_brake_options;
    mscr_opt3_s startup_acceleration_options;
    mscr_opt4_s handover_align_options;
    mscr_opt5_s fault_enable_surge_options;
  } mscr_cfg_s;

  // decoded values handed to the control logic
  typedef struct packed {
    logic [9:0] still_window_ms;
    logic [7:0] advance_angle_deg;
    logic brake_enable;
    logic [11:0] handover_speed_dhz;
    logic handover_speed_valid;
  } mscr_dec_s;

endpackage : mscr_pkg

/* hw/mscr_regs.sv */
// Purpose: start-up configuration register bank of a sensorless motor driver
// Assumes: axi4-lite slave, one write and one read in flight at most
// Notes: each option write with byte lane 0 enabled raises a sticky event bit; read of status clears it
//
// The AXI4-Lite register port was chosen for this implementation.
`timescale 1ns/1ns
module mscr_regs
  import mscr_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output mscr_cfg_s cfg_o,
  output mscr_dec_s dec_o,
  output logic irq_o
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [NUM_OPT-1:0][7:0] opt;
    logic [NUM_OPT-1:0] status;
    logic [NUM_OPT-1:0] mask;
    logic aw_full;
    logic [9:0] aw_idx;
    logic w_full;
    logic [7:0] w_byte;
    logic w_lane0;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [7:0] rdata;
    logic [1:0] rresp;
  } mscr_state_s;

  mscr_state_s s_q;
  mscr_state_s s_d;

  localparam mscr_state_s RST_STATE = '{
    opt: {NUM_OPT{RST_OPT}},
    status: '0,
    mask: RST_MASK,
    aw_full: 1'b0,
    aw_idx: '0,
    w_full: 1'b0,
    w_byte: '0,
    w_lane0: 1'b0,
    bvalid: 1'b0,
    bresp: RESP_OKAY,
    rvalid: 1'b0,
    rdata: '0,
    rresp: RESP_OKAY
  };

  logic aw_take;
  logic w_take;
  logic ar_take;
  logic do_write;
  logic [NUM_OPT-1:0] wr_event;
  logic [NUM_OPT-1:0] rd_clear;
  logic [9:0] ar_idx;

  // each write channel is free until its own half is held, and refused while an answer is pending
  assign s_axi_awready = !s_q.aw_full && !s_q.bvalid;
  assign s_axi_wready = !s_q.w_full && !s_q.bvalid;
  assign s_axi_arready = !s_q.rvalid;
  assign aw_take = s_axi_awvalid && s_axi_awready;
  assign w_take = s_axi_wvalid && s_axi_wready;
  assign ar_take = s_axi_arvalid && s_axi_arready;
  assign do_write = s_q.aw_full && s_q.w_full && !s_q.bvalid;
  assign ar_idx = s_axi_araddr[ADDR_W-1:2];

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    wr_event = '0;
    rd_clear = '0;

    if (aw_take) begin
      s_d.aw_full = 1'b1;
      s_d.aw_idx = s_axi_awaddr[ADDR_W-1:2];
    end
    if (w_take) begin
      s_d.w_full = 1'b1;
      s_d.w_byte = s_axi_wdata[7:0];
      s_d.w_lane0 = s_axi_wstrb[0];
    end

    // commit a held write; option registers keep the last value written
    if (do_write) begin
      s_d.aw_full = 1'b0;
      s_d.w_full = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = RESP_OKAY;
      if (s_q.aw_idx >= IDX_DETECT_REVERSE && s_q.aw_idx <= IDX_FAULT_SURGE) begin
        for (int i = 0; i < NUM_OPT; i++) begin
          if (s_q.aw_idx == IDX_DETECT_REVERSE + 10'(i) && s_q.w_lane0) begin
            s_d.opt[i] = s_q.w_byte;
            wr_event[i] = 1'b1;
          end
        end
      end else if (s_q.aw_idx == IDX_EVENT_MASK) begin
        if (s_q.w_lane0) begin
          s_d.mask = s_q.w_byte[NUM_OPT-1:0];
        end
      end else if (s_q.aw_idx != IDX_EVENT_STATUS) begin
        s_d.bresp = RESP_SLVERR;
      end
    end
    if (s_q.bvalid && s_axi_bready) begin
      s_d.bvalid = 1'b0;
    end

    // read answers one cycle after the address is taken
    if (ar_take) begin
      s_d.rvalid = 1'b1;
      s_d.rresp = RESP_OKAY;
      s_d.rdata = '0;
      if (ar_idx >= IDX_DETECT_REVERSE && ar_idx <= IDX_FAULT_SURGE) begin
        for (int i = 0; i < NUM_OPT; i++) begin
          if (ar_idx == IDX_DETECT_REVERSE + 10'(i)) begin
            s_d.rdata = s_q.opt[i];
          end
        end
      end else if (ar_idx == IDX_EVENT_STATUS) begin
        s_d.rdata = {3'h0, s_q.status};
        rd_clear = s_q.status;
      end else if (ar_idx == IDX_EVENT_MASK) begin
        s_d.rdata = {3'h0, s_q.mask};
      end else begin
        s_d.rresp = RESP_SLVERR;
      end
    end else if (s_q.rvalid && s_axi_rready) begin
      s_d.rvalid = 1'b0;
    end

    // a new event wins over a read that clears in the same cycle
    s_d.status = (s_q.status & ~rd_clear) | wr_event;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_q <= RST_STATE;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign s_axi_bvalid = s_q.bvalid;
  assign s_axi_bresp = s_q.bresp;
  assign s_axi_rvalid = s_q.rvalid;
  assign s_axi_rresp = s_q.rresp;
  assign s_axi_rdata = {24'h000000, s_q.rdata};
  assign irq_o = |(s_q.status & s_q.mask);

  // fields go straight from the flops; option 1 takes the top byte
  logic [NUM_OPT*8-1:0] cfg_word;
  for (genvar g = 0; g < NUM_OPT; g++) begin : g_cfg
    assign cfg_word[(NUM_OPT-1-g)*8 +: 8] = s_q.opt[g];
  end
  assign cfg_o = mscr_cfg_s'(cfg_word);

  logic [1:0] still_code;
  logic [1:0] adv_code;
  logic [4:0] hand_code;
  assign still_code = cfg_o.detect_reverse_options.stationary_judge_threshold;
  assign adv_code = cfg_o.detect_reverse_options.post_sense_advance_angle;
  assign hand_code = cfg_o.handover_align_options.closed_loop_handover_speed;

  // window doubles per code step from 80 ms
  assign dec_o.still_window_ms = STILL_WINDOW_BASE_MS << still_code;
  assign dec_o.advance_angle_deg = 8'(ADVANCE_STEP_DEG * ({6'h00, adv_code} + 8'h01));
  assign dec_o.brake_enable = |cfg_o.open_loop_current_brake_options.brake_time_select;

  // handover speed in tenths of a hertz
  assign dec_o.handover_speed_dhz = hand_code[4] ?
    12'(HANDOVER_HIGH_STEP_DHZ * ({8'h00, hand_code[3:0]} + 12'h001)) :
    12'(HANDOVER_LOW_STEP_DHZ * {8'h00, hand_code[3:0]});
  assign dec_o.handover_speed_valid = hand_code[4] || (|hand_code[3:0]);

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  opt_write_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    (do_write && s_q.w_lane0 && s_q.aw_idx == IDX_DETECT_REVERSE)
      |=> (s_q.opt[0] == $past(s_q.w_byte)) && s_q.status[0])
    else $error("option write not stored");

  opt_stable_a: assert property (@(posedge clk) disable iff (!rst_n)
    !$past(do_write) |-> $stable(s_q.opt))
    else $error("option register changed without a write");

  read_back_a: assert property (@(posedge clk) disable iff (!rst_n)
    (ar_take && ar_idx == IDX_FAULT_SURGE) |=> s_axi_rvalid && s_axi_rdata[7:0] == $past(s_q.opt[4]))
    else $error("option read does not return stored value");

  still_window_a: assert property (@(posedge clk) disable iff (!rst_n)
    (still_code == 2'h3) |-> dec_o.still_window_ms == 10'h280)
    else $error("still window wrong for longest code");

  advance_angle_a: assert property (@(posedge clk) disable iff (!rst_n)
    (adv_code == 2'h3) |-> dec_o.advance_angle_deg == 8'h78)
    else $error("advance angle wrong");

  brake_off_a: assert property (@(posedge clk) disable iff (!rst_n)
    dec_o.brake_enable == (s_q.opt[1][2:0] != 3'h0))
    else $error("brake enable does not follow brake field");

  handover_range_a: assert property (@(posedge clk) disable iff (!rst_n)
    (hand_code == 5'h1f) |-> dec_o.handover_speed_dhz == 12'h800 && dec_o.handover_speed_valid)
    else $error("handover top speed wrong");

  handover_zero_a: assert property (@(posedge clk) disable iff (!rst_n)
    (hand_code == 5'h00) |-> !dec_o.handover_speed_valid)
    else $error("zero handover code flagged valid");

  fault_bits_a: assert property (@(posedge clk) disable iff (!rst_n)
    cfg_o.fault_enable_surge_options.no_motor_fault_enable == s_q.opt[4][7]
      && cfg_o.fault_enable_surge_options.sense_release_mode == s_q.opt[4][0])
    else $error("fault or surge field misplaced");

  event_wins_a: assert property (@(posedge clk) disable iff (!rst_n)
    (|wr_event && |rd_clear) |=> (s_q.status & $past(wr_event)) == $past(wr_event))
    else $error("event lost against status clear");

  irq_level_a: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(irq_o) |-> $past(do_write) && |s_q.mask)
    else $error("interrupt rose without a write event");

  // ----------------------------------------------------------------
  // bus answer, register, field placement and decode checks
  // ----------------------------------------------------------------

  write_answer_a: assert property (@(posedge clk) disable iff (!rst_n)
    (aw_take && w_take)
      |=> ##1 s_axi_bvalid)
    else $error("write answer not two cycles after both halves taken");

  write_refused_a: assert property (@(posedge clk) disable iff (!rst_n)
    s_axi_bvalid
      |-> !s_axi_awready && !s_axi_wready)
    else $error("write half accepted while answer pending");

  read_answer_a: assert property (@(posedge clk) disable iff (!rst_n)
    ar_take
      |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer not one cycle after address");

  rdata_upper_a: assert property (@(posedge clk) disable iff (!rst_n)
    s_axi_rvalid
      |-> s_axi_rdata[31:8] == 24'h000000)
    else $error("read data upper bytes not zero");

  bad_write_a: assert property (@(posedge clk) disable iff (!rst_n)
    (do_write && s_q.aw_idx < IDX_DETECT_REVERSE)
      |=> s_axi_bvalid && s_axi_bresp == RESP_SLVERR)
    else $error("unmapped write not refused");

  bad_read_a: assert property (@(posedge clk) disable iff (!rst_n)
    (ar_take && ar_idx < IDX_DETECT_REVERSE)
      |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h00000000)
    else $error("unmapped read not refused");

  opt_write_okay_a: assert property (@(posedge clk) disable iff (!rst_n)
    (do_write && s_q.aw_idx >= IDX_DETECT_REVERSE && s_q.aw_idx <= IDX_FAULT_SURGE)
      |=> s_axi_bvalid && s_axi_bresp == RESP_OKAY)
    else $error("option write not answered okay");

  status_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
    (ar_take && ar_idx == IDX_EVENT_STATUS && !(|wr_event))
      |=> !(|s_q.status))
    else $error("status not cleared by its read");

  status_read_a: assert property (@(posedge clk) disable iff (!rst_n)
    (ar_take && ar_idx == IDX_EVENT_STATUS)
      |=> s_axi_rdata[NUM_OPT-1:0] == $past(s_q.status))
    else $error("status read returns wrong bits");

  strobe_off_a: assert property (@(posedge clk) disable iff (!rst_n)
    (do_write && !s_q.w_lane0)
      |=> $stable(s_q.opt) && $stable(s_q.mask))
    else $error("write without byte enable changed a register");

  mask_write_a: assert property (@(posedge clk) disable iff (!rst_n)
    (do_write && s_q.w_lane0 && s_q.aw_idx == IDX_EVENT_MASK)
      |=> s_q.mask == NUM_OPT'($past(s_q.w_byte)))
    else $error("mask write not stored");

  last_write_a: assert property (@(posedge clk) disable iff (!rst_n)
    (do_write && s_q.w_lane0 && s_q.aw_idx == IDX_FAULT_SURGE)
      |=> s_q.opt[4] == $past(s_q.w_byte) && s_q.status[4])
    else $error("last option write not stored");

  detect_bits_a: assert property (@(posedge clk) disable iff (!rst_n)
    cfg_o.detect_reverse_options.initial_speed_detect_enable == s_q.opt[0][3]
      && cfg_o.detect_reverse_options.reverse_drive_enable == s_q.opt[0][2]
      && cfg_o.detect_reverse_options.reverse_brake_threshold == s_q.opt[0][1:0])
    else $error("detect or reverse field misplaced");

  current_bits_a: assert property (@(posedge clk) disable iff (!rst_n)
    cfg_o.open_loop_current_brake_options.open_loop_current == s_q.opt[1][7:6]
      && cfg_o.open_loop_current_brake_options.open_loop_ramp_rate == s_q.opt[1][5:3])
    else $error("open-loop current field misplaced");

  accel_bits_a: assert property (@(posedge clk) disable iff (!rst_n)
    cfg_o.startup_acceleration_options.startup_accel_second_order == s_q.opt[2][5:3]
      && cfg_o.startup_acceleration_options.startup_accel_first_order == s_q.opt[2][2:0])
    else $error("start-up acceleration field misplaced");

  align_bits_a: assert property (@(posedge clk) disable iff (!rst_n)
    cfg_o.handover_align_options.closed_loop_handover_speed == s_q.opt[3][7:3]
      && cfg_o.handover_align_options.rotor_align_time == s_q.opt[3][2:0])
    else $error("handover or align field misplaced");

  surge_bits_a: assert property (@(posedge clk) disable iff (!rst_n)
    cfg_o.fault_enable_surge_options.lock_detector_enables == s_q.opt[4][6:4]
      && cfg_o.fault_enable_surge_options.inductive_surge_guard_enable == s_q.opt[4][3]
      && cfg_o.fault_enable_surge_options.mechanical_surge_guard_enable == s_q.opt[4][2]
      && cfg_o.fault_enable_surge_options.mechanical_surge_guard_target == s_q.opt[4][1])
    else $error("detector or surge field misplaced");

  still_window_low_a: assert property (@(posedge clk) disable iff (!rst_n)
    ((still_code == 2'h0) |-> dec_o.still_window_ms == 10'h050)
      and ((still_code == 2'h1) |-> dec_o.still_window_ms == 10'h0a0)
      and ((still_code == 2'h2) |-> dec_o.still_window_ms == 10'h140))
    else $error("still window wrong for short codes");

  advance_low_a: assert property (@(posedge clk) disable iff (!rst_n)
    ((adv_code == 2'h0) |-> dec_o.advance_angle_deg == 8'h1e)
      and ((adv_code == 2'h1) |-> dec_o.advance_angle_deg == 8'h3c)
      and ((adv_code == 2'h2) |-> dec_o.advance_angle_deg == 8'h5a))
    else $error("advance angle wrong for small codes");

  handover_low_a: assert property (@(posedge clk) disable iff (!rst_n)
    ((hand_code == 5'h01) |-> dec_o.handover_speed_dhz == 12'h008 && dec_o.handover_speed_valid)
      and ((hand_code == 5'h0f) |-> dec_o.handover_speed_dhz == 12'h078))
    else $error("low range handover speed wrong");

  handover_high_a: assert property (@(posedge clk) disable iff (!rst_n)
    ((hand_code == 5'h10) |-> dec_o.handover_speed_dhz == 12'h080 && dec_o.handover_speed_valid)
      and ((hand_code == 5'h11) |-> dec_o.handover_speed_dhz == 12'h100))
    else $error("high range handover speed wrong");

endmodule : mscr_regs

/* test/tb_mscr_regs.sv */
// Purpose: self-checking bench for the motor start-up configuration register bank
// Assumes: axi4-lite master tasks, at most one write and one read under way at a time
// Notes: option byte address is index times four; status and mask sit above them at indices 0x30 and 0x31
`timescale 1ns/1ns
module tb_mscr_regs
  import mscr_pkg::*;
;
  logic clk;
  logic rst_n;
  logic [11:0] awaddr;
  logic [11:0] araddr;
  logic awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, irq;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp;
  logic [1:0] rresp;
  mscr_cfg_s cfg;
  mscr_dec_s dec;
  int err_total;
  int n_compared;
  int i;
  logic [7:0] v [5];
  logic [4:0] hc [7];
  int hs [7];

  mscr_regs i_mscr_regs (
    .clk(clk),
    .rst_n(rst_n),
    .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid),
    .s_axi_awready(awready),
    .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid),
    .s_axi_wready(wready),
    .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid),
    .s_axi_bready(bready),
    .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid),
    .s_axi_arready(arready),
    .s_axi_rdata(rdata),
    .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid),
    .s_axi_rready(rready),
    .cfg_o(cfg),
    .dec_o(dec),
    .irq_o(irq)
  );

  initial clk = 1'b0;
  always #25 clk = ~clk;

  // ------------------------------------------------------------
  // compare and report
  // ------------------------------------------------------------
  task automatic summarize();
    if (err_total == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : summarize

  task automatic cmp_word(input logic [39:0] g, input logic [39:0] e);
    n_compared++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : cmp_word

  task automatic cmp_resp(input logic [1:0] g, input logic [1:0] e);
    n_compared++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] t=%0t resp got=%h exp=%h", $time, g, e);
    end
  endtask : cmp_resp

  // ------------------------------------------------------------
  // bus tasks: handshakes sampled at the falling edge, acted on at the rising edge
  // ------------------------------------------------------------
  task automatic wr(input logic [9:0] idx, input logic [7:0] d, input logic [3:0] s, input logic [1:0] er);
    int n;
    logic a_ok, w_ok, b_ok;
    logic [1:0] r;
    @(posedge clk);
    awaddr <= {idx, 2'b00};
    wdata <= {24'h5a5a5a, d};
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    b_ok = 1'b0;
    n = 0;
    while (!b_ok && n < 50) begin
      @(negedge clk);
      a_ok = awvalid && awready;
      w_ok = wvalid && wready;
      b_ok = (bvalid === 1'b1);
      r = bresp;
      @(posedge clk);
      if (a_ok) awvalid <= 1'b0;
      if (w_ok) wvalid <= 1'b0;
      n++;
    end
    bready <= 1'b0;
    cmp_resp(r, er);
    if (!b_ok) begin
      err_total++;
      summarize();
    end
  endtask : wr

  task automatic rd(input logic [9:0] idx, input logic [31:0] ed, input logic [1:0] er);
    int n;
    logic a_ok, r_ok;
    logic [31:0] d;
    logic [1:0] r;
    @(posedge clk);
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    r_ok = 1'b0;
    n = 0;
    while (!r_ok && n < 50) begin
      @(negedge clk);
      a_ok = arvalid && arready;
      r_ok = (rvalid === 1'b1);
      d = rdata;
      r = rresp;
      @(posedge clk);
      if (a_ok) arvalid <= 1'b0;
      n++;
    end
    rready <= 1'b0;
    cmp_word({8'h00, d}, {8'h00, ed});
    cmp_resp(r, er);
    if (!r_ok) begin
      err_total++;
      summarize();
    end
  endtask : rd

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    rst_n = 1'b0;
    awaddr = 12'h000;
    araddr = 12'h000;
    wdata = 32'h0;
    wstrb = 4'h0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    err_total = 0;
    n_compared = 0;
    v = '{8'ha5, 8'h5a, 8'hc3, 8'h3c, 8'h96};
    hc = '{5'h00, 5'h01, 5'h07, 5'h0f, 5'h10, 5'h11, 5'h1f};
    hs = '{0, 8, 56, 120, 128, 256, 2048};
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    cmp_word(40'(cfg), 40'h0);
    cmp_word(40'(dec), {8'h00, 10'h050, 8'h1e, 1'b0, 12'h000, 1'b0});
    cmp_word(40'(irq), 40'h0);
    for (i = 0; i < 5; i++) rd(IDX_DETECT_REVERSE + 10'(i), 32'h0, RESP_OKAY);
    // distinct pattern in every option, upper write bytes ignored
    for (i = 0; i < 5; i++) wr(IDX_DETECT_REVERSE + 10'(i), v[i], 4'h1, RESP_OKAY);
    for (i = 0; i < 5; i++) rd(IDX_DETECT_REVERSE + 10'(i), {24'h0, v[i]}, RESP_OKAY);
    @(negedge clk);
    cmp_word(cfg, {v[0], v[1], v[2], v[3], v[4]});
    // a write with no byte enable leaves the option alone
    wr(IDX_STARTUP_ACCEL, 8'h00, 4'h0, RESP_OKAY);
    rd(IDX_STARTUP_ACCEL, {24'h0, v[2]}, RESP_OKAY);
    // event status, mask and interrupt
    @(negedge clk);
    cmp_word(40'(irq), 40'h0);
    rd(IDX_EVENT_STATUS, 32'h1f, RESP_OKAY);
    rd(IDX_EVENT_STATUS, 32'h0, RESP_OKAY);
    wr(IDX_EVENT_MASK, 8'h04, 4'h1, RESP_OKAY);
    rd(IDX_EVENT_MASK, 32'h4, RESP_OKAY);
    wr(IDX_DETECT_REVERSE, 8'h00, 4'h1, RESP_OKAY);
    @(negedge clk);
    cmp_word(40'(irq), 40'h0);
    wr(IDX_STARTUP_ACCEL, v[2], 4'h1, RESP_OKAY);
    @(negedge clk);
    cmp_word(40'(irq), 40'h1);
    // status read clears in the very cycle a new write event lands; the event stays
    fork
      wr(IDX_FAULT_SURGE, v[4], 4'h1, RESP_OKAY);
      begin
        @(posedge clk);
        rd(IDX_EVENT_STATUS, 32'h5, RESP_OKAY);
      end
    join
    @(negedge clk);
    cmp_word(40'(irq), 40'h0);
    rd(IDX_EVENT_STATUS, 32'h10, RESP_OKAY);
    // decoded fields over all still, advance and brake codes and seven handover codes
    for (i = 0; i < 4; i++) begin
      wr(IDX_DETECT_REVERSE, {2'(i), 2'(i), 4'h0}, 4'h1, RESP_OKAY);
      @(negedge clk);
      cmp_word(40'(dec.still_window_ms), 40'(80 << i));
      cmp_word(40'(dec.advance_angle_deg), 40'(30 * (i + 1)));
    end
    for (i = 0; i < 8; i++) begin
      wr(IDX_CURRENT_BRAKE, {5'h00, 3'(i)}, 4'h1, RESP_OKAY);
      @(negedge clk);
      cmp_word(40'(dec.brake_enable), 40'(i != 0));
    end
    for (i = 0; i < 7; i++) begin
      wr(IDX_HANDOVER_ALIGN, {hc[i], 3'h5}, 4'h1, RESP_OKAY);
      @(negedge clk);
      cmp_word(40'(dec.handover_speed_dhz), 40'(hs[i]));
      cmp_word(40'(dec.handover_speed_valid), 40'(i != 0));
      cmp_word(40'(cfg.handover_align_options), {32'h0, hc[i], 3'h5});
    end
    // unmapped word answers with an error
    wr(10'h001, 8'hff, 4'h1, RESP_SLVERR);
    rd(10'h001, 32'h0, RESP_SLVERR);
    summarize();
  end
endmodule : tb_mscr_regs
